//--- hdl/tmc_pkg.sv
// constants, types and state layout of the dual timer/counter
// How it works
// - two independent 16-bit timer/counters, each timer or event counter
// - basic mode chains low and high byte, low carry bumps high byte
// - run bit lets selected source increment low byte; clear freezes count, but timer 1 ignores its run bit while timer 0 is in mode 3
// - setting run bit keeps both count bytes unchanged
// - count bytes readable anytime; software stops timer before presetting
// - source select 0 counts peripheral cycles, 1 counts the count pin
// - timer mode increments once per six-clock peripheral cycle
// - count pin sampled each peripheral cycle; high then low counts one
// - edge recognition spans two peripheral cycles, max rate clock/12
// - gate clear: run alone enables; gate set: interrupt pin must be high
// - rollover from all ones to zero sets the overflow flag
// - timer 0 takes gate, source and mode from mode register low nibble
// - timer 0 uses control bits 0, 1, 4 and 5
// - timer 0 offers four modes, each as timer or counter
// - mode 0 is high byte behind a divide-by-32 low-byte prescaler
// - mode 2 reloads the 8-bit low byte from untouched high byte
// - timer 0 mode 3 splits; high byte times, borrows timer 1 run/flag
// - timer 1 in mode 3 halts and holds its count
package tmc_pkg;

  localparam int DATA_W = 32;
  localparam int ADR_W = 8;

  // byte addresses of the word registers
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_LOW0 = 8'h08;
  localparam logic [7:0] ADR_HIGH0 = 8'h0c;
  localparam logic [7:0] ADR_LOW1 = 8'h10;
  localparam logic [7:0] ADR_HIGH1 = 8'h14;

  // control register: per timer x, bit = base + stride * x
  localparam int CTRL_STRIDE = 2;
  localparam int CTRL_IT_BASE = 0;
  localparam int CTRL_IE_BASE = 1;
  localparam int CTRL_TR_BASE = 4;
  localparam int CTRL_TF_BASE = 5;

  // mode register: one nibble per timer
  localparam int MODE_NIB_W = 4;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_SRC_POS = 2;
  localparam int MODE_GATE_POS = 3;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  localparam logic [2:0] PER_CYCLE_CLKS = 3'h6;

  typedef enum logic [1:0] {
    TMC_MODE_13BIT = 2'b00,
    TMC_MODE_16BIT = 2'b01,
    TMC_MODE_RELOAD = 2'b10,
    TMC_MODE_SPLIT = 2'b11
  } tmc_mode_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } tmc_step_t;

  typedef struct packed {
    logic [1:0][7:0] low;
    logic [1:0][7:0] high;
    logic [7:0] mode_reg;
    logic [7:0] ctrl_reg;
    logic [2:0] presc;
    logic [1:0] cnt_s1;
    logic [1:0] cnt_s2;
    logic [1:0] cnt_prev;
    logic [1:0] int_s1;
    logic [1:0] int_s2;
    logic [1:0] int_prev;
    logic ack;
    logic [31:0] rdata;
  } tmc_state_t;

endpackage : tmc_pkg

//--- hdl/tmc_core.sv
// dual timer/counter core with a classic wishbone register slave
//
// Chosen here: the placing of the registers and register access over Wishbone.
module tmc_core (
  input wire logic CORE_CLK_IN, // 40 MHz core clock
  input wire logic RST_B_IN, // async reset, active low
  input wire logic CLK_EN_IN, // freezes all state while low
  input wire logic WB_CYC_IN, // wishbone cycle
  input wire logic WB_STB_IN, // wishbone strobe
  input wire logic WB_WE_IN, // wishbone write enable
  input wire logic [7:0] WB_ADR_IN, // wishbone byte address
  input wire logic [3:0] WB_SEL_IN, // wishbone byte selects
  input wire logic [31:0] WB_DAT_IN, // wishbone write data
  output logic [31:0] WB_DAT_OUT, // wishbone read data
  output logic WB_ACK_OUT, // wishbone acknowledge
  input wire logic [1:0] COUNT_PIN_IN, // external count pins, async
  input wire logic [1:0] EXT_INT_PIN_B_IN, // external irq pins, async
  input wire logic [3:0] IRQ_SERVICE_IN, // service: ext0,ovf0,ext1,ovf1
  output logic [1:0] OVF_FLAG_OUT, // overflow flags per timer
  output logic [1:0] EXT_FLAG_OUT // external irq flags per pin
);

  tmc_pkg::tmc_state_t st;
  tmc_pkg::tmc_state_t next_st;

  // one increment step of a timer pair in the given mode
  function automatic tmc_pkg::tmc_step_t tmc_step(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic inc
  );
    tmc_pkg::tmc_step_t r;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    if (inc) begin
      case (mode)
        tmc_pkg::TMC_MODE_13BIT: begin
          // upper three low bits never move
          r.lo[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == 5'h1f) begin
            r.hi = hi + 8'h01;
            r.ovf = (hi == 8'hff);
          end
        end
        tmc_pkg::TMC_MODE_16BIT: begin
          r.lo = lo + 8'h01;
          if (lo == 8'hff) begin
            r.hi = hi + 8'h01;
            r.ovf = (hi == 8'hff);
          end
        end
        tmc_pkg::TMC_MODE_RELOAD: begin
          if (lo == 8'hff) begin
            r.lo = hi;
            r.ovf = 1'b1;
          end else begin
            r.lo = lo + 8'h01;
          end
        end
        default: begin
          // split mode: low byte is a plain 8-bit counter
          r.lo = lo + 8'h01;
          r.ovf = (lo == 8'hff);
        end
      endcase
    end
    return r;
  endfunction : tmc_step

  logic tick;
  logic req;
  logic wr_now;
  logic t0_split;
  logic [1:0] cnt_edge;
  logic [1:0] int_fall;
  logic [1:0] run;
  logic [1:0] inc;
  logic [1:0] set_tf;
  logic [1:0] set_ie;
  logic [3:0] nib0;
  logic [3:0] nib1;
  logic hi0_inc;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  tmc_pkg::tmc_step_t step0;
  tmc_pkg::tmc_step_t step1;

  always_comb begin
    next_st = st;
    req = WB_CYC_IN & WB_STB_IN;
    // writes land on the edge where the master sees ack
    wr_now = req & st.ack & WB_WE_IN & WB_SEL_IN[0];
    wbyte = WB_DAT_IN[7:0];
    nib0 = st.mode_reg[0 +: tmc_pkg::MODE_NIB_W];
    nib1 = st.mode_reg[tmc_pkg::MODE_NIB_W +: tmc_pkg::MODE_NIB_W];
    t0_split = (nib0[tmc_pkg::MODE_SEL_LSB +: 2] == tmc_pkg::TMC_MODE_SPLIT);

    // peripheral cycle of six core clocks
    tick = (st.presc == tmc_pkg::PER_CYCLE_CLKS - 3'h1);
    next_st.presc = tick ? 3'h0 : st.presc + 3'h1;

    // pin synchronisers; first stage feeds only the second
    next_st.cnt_s1 = COUNT_PIN_IN;
    next_st.cnt_s2 = st.cnt_s1;
    next_st.int_s1 = EXT_INT_PIN_B_IN;
    next_st.int_s2 = st.int_s1;
    next_st.int_prev = st.int_s2;
    if (tick) begin
      next_st.cnt_prev = st.cnt_s2;
    end
    // high sample then low sample one peripheral cycle apart
    cnt_edge = {2{tick}} & st.cnt_prev & ~st.cnt_s2;
    int_fall = st.int_prev & ~st.int_s2;

    // timer 1 run bit is lent to the split high byte
    run[0] = st.ctrl_reg[tmc_pkg::CTRL_TR_BASE];
    run[1] = t0_split ? 1'b1
      : st.ctrl_reg[tmc_pkg::CTRL_TR_BASE + tmc_pkg::CTRL_STRIDE];

    // gate lets the interrupt pin (high = permit) qualify run
    inc[0] = run[0]
      & (~nib0[tmc_pkg::MODE_GATE_POS] | st.int_s2[0])
      & (nib0[tmc_pkg::MODE_SRC_POS] ? cnt_edge[0] : tick);
    inc[1] = run[1]
      & (~nib1[tmc_pkg::MODE_GATE_POS] | st.int_s2[1])
      & (nib1[tmc_pkg::MODE_SRC_POS] ? cnt_edge[1] : tick)
      & (nib1[tmc_pkg::MODE_SEL_LSB +: 2]
      != tmc_pkg::TMC_MODE_SPLIT);

    step0 = tmc_step(nib0[tmc_pkg::MODE_SEL_LSB +: 2], st.low[0],
      st.high[0], inc[0]);
    step1 = tmc_step(nib1[tmc_pkg::MODE_SEL_LSB +: 2], st.low[1],
      st.high[1], inc[1]);

    next_st.low[0] = step0.lo;
    next_st.high[0] = step0.hi;
    next_st.low[1] = step1.lo;
    next_st.high[1] = step1.hi;
    set_tf[0] = step0.ovf;
    set_tf[1] = ~t0_split & step1.ovf;

    // split mode: high byte of timer 0 times peripheral cycles while the timer 1 run bit is set
    hi0_inc = t0_split & tick
      & st.ctrl_reg[tmc_pkg::CTRL_TR_BASE + tmc_pkg::CTRL_STRIDE];
    if (hi0_inc) begin
      next_st.high[0] = st.high[0] + 8'h01;
      if (st.high[0] == 8'hff) begin
        set_tf[1] = 1'b1;
      end
    end

    // external interrupt flags: edge or low level by type bit
    set_ie[0] = st.ctrl_reg[tmc_pkg::CTRL_IT_BASE] ? int_fall[0]
      : ~st.int_s2[0];
    set_ie[1] = st.ctrl_reg[tmc_pkg::CTRL_IT_BASE + tmc_pkg::CTRL_STRIDE]
      ? int_fall[1] : ~st.int_s2[1];

    // software write of the count bytes overrides counting
    if (wr_now) begin
      if (WB_ADR_IN[7:2] == tmc_pkg::ADR_LOW0[7:2]) begin
        next_st.low[0] = wbyte;
      end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_HIGH0[7:2]) begin
        next_st.high[0] = wbyte;
      end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_LOW1[7:2]) begin
        next_st.low[1] = wbyte;
      end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_HIGH1[7:2]) begin
        next_st.high[1] = wbyte;
      end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_MODE[7:2]) begin
        next_st.mode_reg = wbyte;
      end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_CTRL[7:2]) begin
        // run bit changes only the enable, counts stay put
        next_st.ctrl_reg = wbyte;
      end
    end

    // service clears first, so a same-cycle hardware set wins
    if (IRQ_SERVICE_IN[0]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_IE_BASE] = 1'b0;
    end
    if (IRQ_SERVICE_IN[1]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_TF_BASE] = 1'b0;
    end
    if (IRQ_SERVICE_IN[2]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_IE_BASE + tmc_pkg::CTRL_STRIDE] = 1'b0;
    end
    if (IRQ_SERVICE_IN[3]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_TF_BASE + tmc_pkg::CTRL_STRIDE] = 1'b0;
    end
    if (set_tf[0]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_TF_BASE] = 1'b1;
    end
    if (set_tf[1]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_TF_BASE + tmc_pkg::CTRL_STRIDE] = 1'b1;
    end
    if (set_ie[0]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_IE_BASE] = 1'b1;
    end
    if (set_ie[1]) begin
      next_st.ctrl_reg[tmc_pkg::CTRL_IE_BASE + tmc_pkg::CTRL_STRIDE] = 1'b1;
    end

    // read data captured as ack rises; unmapped reads give zero
    if (WB_ADR_IN[7:2] == tmc_pkg::ADR_CTRL[7:2]) begin
      rbyte = st.ctrl_reg;
    end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_MODE[7:2]) begin
      rbyte = st.mode_reg;
    end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_LOW0[7:2]) begin
      rbyte = st.low[0];
    end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_HIGH0[7:2]) begin
      rbyte = st.high[0];
    end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_LOW1[7:2]) begin
      rbyte = st.low[1];
    end else if (WB_ADR_IN[7:2] == tmc_pkg::ADR_HIGH1[7:2]) begin
      rbyte = st.high[1];
    end else begin
      rbyte = 8'h00;
    end
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      next_st.rdata = {24'h00_0000, rbyte};
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st.low <= {2{tmc_pkg::COUNT_RST}};
      st.high <= {2{tmc_pkg::COUNT_RST}};
      st.mode_reg <= tmc_pkg::MODE_RST;
      st.ctrl_reg <= tmc_pkg::CTRL_RST;
      st.presc <= 3'h0;
      st.cnt_s1 <= 2'h0;
      st.cnt_s2 <= 2'h0;
      st.cnt_prev <= 2'h0;
      // interrupt pins idle high, so no false fall after reset
      st.int_s1 <= 2'h3;
      st.int_s2 <= 2'h3;
      st.int_prev <= 2'h3;
      st.ack <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else if (CLK_EN_IN) begin
      st <= next_st;
    end
  end

  assign WB_DAT_OUT = st.rdata;
  assign WB_ACK_OUT = st.ack;
  assign OVF_FLAG_OUT = {
    st.ctrl_reg[tmc_pkg::CTRL_TF_BASE + tmc_pkg::CTRL_STRIDE],
    st.ctrl_reg[tmc_pkg::CTRL_TF_BASE]};
  assign EXT_FLAG_OUT = {
    st.ctrl_reg[tmc_pkg::CTRL_IE_BASE + tmc_pkg::CTRL_STRIDE],
    st.ctrl_reg[tmc_pkg::CTRL_IE_BASE]};

endmodule : tmc_core

//--- bench/tmc_core_props.sv
// port-level assertions for the timer/counter core
module tmc_core_props (
  input wire logic CORE_CLK_IN, // clock
  input wire logic RST_B_IN, // reset, active low
  input wire logic CLK_EN_IN, // clock enable
  input wire logic WB_CYC_IN, // cycle
  input wire logic WB_STB_IN, // strobe
  input wire logic WB_WE_IN, // write
  input wire logic [7:0] WB_ADR_IN, // address
  input wire logic [3:0] WB_SEL_IN, // selects
  input wire logic [31:0] WB_DAT_IN, // write data
  input wire logic [31:0] WB_DAT_OUT, // read data
  input wire logic WB_ACK_OUT, // acknowledge
  input wire logic [1:0] COUNT_PIN_IN, // count pins
  input wire logic [1:0] EXT_INT_PIN_B_IN, // gate pins
  input wire logic [3:0] IRQ_SERVICE_IN, // service pulses
  input wire logic [1:0] OVF_FLAG_OUT, // overflow flags
  input wire logic [1:0] EXT_FLAG_OUT // external flags
);
  logic req;
  logic wr_ctrl;
  assign req = WB_CYC_IN && WB_STB_IN;
  // control write lands at the edge that samples ack
  assign wr_ctrl = req && WB_WE_IN && WB_ACK_OUT && WB_SEL_IN[0]
    && WB_ADR_IN[7:2] == 6'h00;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  property p_ack_next;
    req && !WB_ACK_OUT && CLK_EN_IN |=> WB_ACK_OUT;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one;
    WB_ACK_OUT && CLK_EN_IN |=> !WB_ACK_OUT;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack long");
  property p_ack_cause;
    $rose(WB_ACK_OUT) |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("lone ack");
  property p_dat_hi;
    WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h00_0000;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("read high bits");
  property p_dat_hold;
    !(req && !WB_ACK_OUT && CLK_EN_IN) |=> $stable(WB_DAT_OUT);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read drift");
  property p_freeze;
    !CLK_EN_IN |=> $stable(OVF_FLAG_OUT) && $stable(WB_ACK_OUT);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved frozen");
  property p_ovf0_clr;
    $fell(OVF_FLAG_OUT[0]) |-> $past(IRQ_SERVICE_IN[1] || wr_ctrl);
  endproperty
  a_ovf0_clr: assert property (p_ovf0_clr) else $error("ovf0 lost");
  property p_ovf1_clr;
    $fell(OVF_FLAG_OUT[1]) |-> $past(IRQ_SERVICE_IN[3] || wr_ctrl);
  endproperty
  a_ovf1_clr: assert property (p_ovf1_clr) else $error("ovf1 lost");
endmodule : tmc_core_props
bind tmc_core tmc_core_props u_props (.CORE_CLK_IN, .RST_B_IN, .CLK_EN_IN,
  .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN,
  .WB_DAT_OUT, .WB_ACK_OUT, .COUNT_PIN_IN, .EXT_INT_PIN_B_IN,
  .IRQ_SERVICE_IN, .OVF_FLAG_OUT, .EXT_FLAG_OUT);

//--- bench/tmc_pins.sv
// far-side model of the count and gate pins
module tmc_pins (
  input wire logic clk_in, // core clock
  output logic [1:0] count_out, // count pins
  output logic [1:0] gate_b_out // gate pins, active low
);
  timeunit 1ns;
  timeprecision 100ps;
  // each level outlasts one six-clock peripheral cycle
  localparam int HOLD = 8;
  initial begin
    count_out = 2'b11;
    gate_b_out = 2'b11;
  end
  task automatic falls(input int idx, input int n);
    repeat (n) begin
      count_out[idx] <= 1'b0;
      repeat (HOLD) @(posedge clk_in);
      count_out[idx] <= 1'b1;
      repeat (HOLD) @(posedge clk_in);
    end
  endtask : falls
  task automatic gate(input int idx, input logic v);
    gate_b_out[idx] <= v;
  endtask : gate
endmodule : tmc_pins

//--- bench/tmc_core_tb_top.sv
// self-checking bench for the timer/counter core
module tmc_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CT = tmc_pkg::ADR_CTRL;
  localparam logic [7:0] MD = tmc_pkg::ADR_MODE;
  localparam logic [7:0] L0 = tmc_pkg::ADR_LOW0;
  localparam logic [7:0] H0 = tmc_pkg::ADR_HIGH0;
  localparam logic [7:0] L1 = tmc_pkg::ADR_LOW1;
  localparam logic [7:0] H1 = tmc_pkg::ADR_HIGH1;
  logic clk, rst_b, clk_en, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel, svc;
  logic [31:0] wdat, rdat, q;
  logic [1:0] ovf, ext, pin, gate_b;
  int n_errors, compares, ticks, k;
  tmc_core dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(clk_en),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .COUNT_PIN_IN(pin), .EXT_INT_PIN_B_IN(gate_b), .IRQ_SERVICE_IN(svc),
    .OVF_FLAG_OUT(ovf), .EXT_FLAG_OUT(ext));
  tmc_pins pins (.clk_in(clk), .count_out(pin), .gate_b_out(gate_b));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // request held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, logic [7:0] a, logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rchk(input string n, logic [7:0] a, logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, {24'h00_0000, e}, q);
  endtask : rchk
  task automatic wait_ovf(input int i);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ovf[i] !== 1'b1);
  endtask : wait_ovf
  task automatic setup(input logic [7:0] m, lo, hi, run);
    wb(1'b1, CT, 8'h00);
    wb(1'b1, MD, m);
    wb(1'b1, L0, lo);
    wb(1'b1, H0, hi);
    wb(1'b1, CT, run);
  endtask : setup
  task automatic t_reset();
    rchk("ctrl", CT, 8'h00);
    rchk("mode", MD, 8'h00);
    rchk("unmapped", 8'h18, 8'h00);
  endtask : t_reset
  task automatic t_carry();
    setup(8'h01, 8'hfe, 8'hff, 8'h10);
    wait_ovf(0);
    chk("ovf delay", 1, k >= 7 && k <= 15);
    wb(1'b1, CT, 8'h20);
    rchk("low wrap", L0, 8'h00);
    rchk("high wrap", H0, 8'h00);
    svc <= 4'h2;
    @(posedge clk);
    svc <= 4'h0;
    @(posedge clk);
    chk("ovf serviced", 0, ovf[0]);
  endtask : t_carry
  task automatic t_pin();
    setup(8'h05, 8'h00, 8'h00, 8'h10);
    pins.falls(0, 3);
    repeat (14) @(posedge clk);
    wb(1'b1, CT, 8'h00);
    rchk("pin count", L0, 8'h03);
  endtask : t_pin
  task automatic t_gate();
    pins.gate(0, 1'b0);
    setup(8'h09, 8'h40, 8'h00, 8'h10);
    repeat (30) @(posedge clk);
    rchk("gated", L0, 8'h40);
    chk("ext flag", 1, ext);
    pins.gate(0, 1'b1);
    repeat (60) @(posedge clk);
    wb(1'b1, CT, 8'h00);
    wb(1'b0, L0, 8'h00);
    chk("gate open", 1, q >= 32'h49 && q <= 32'h4c);
    chk("ext clear", 0, ext);
  endtask : t_gate
  task automatic t_mode0();
    setup(8'h00, 8'hff, 8'hff, 8'h10);
    wait_ovf(0);
    wb(1'b1, CT, 8'h00);
    rchk("prescale", L0, 8'he0);
  endtask : t_mode0
  task automatic t_reload();
    setup(8'h02, 8'hfe, 8'hf0, 8'h10);
    wait_ovf(0);
    wb(1'b1, CT, 8'h00);
    rchk("reload", L0, 8'hf0);
    rchk("reload src", H0, 8'hf0);
  endtask : t_reload
  task automatic t_split();
    wb(1'b1, L1, 8'h05);
    setup(8'h33, 8'h00, 8'hff, 8'h40);
    wait_ovf(1);
    wb(1'b1, CT, 8'h80);
    // service held off while frozen, taken at the first enabled edge
    clk_en <= 1'b0;
    svc <= 4'h8;
    repeat (4) @(posedge clk);
    chk("frozen ovf1", 1, ovf[1]);
    clk_en <= 1'b1;
    @(posedge clk);
    svc <= 4'h0;
    @(posedge clk);
    chk("ovf1 serviced", 0, ovf[1]);
    rchk("split high", H0, 8'h00);
    rchk("held", L1, 8'h05);
  endtask : t_split
  task automatic t_timer1();
    wb(1'b1, CT, 8'h00);
    wb(1'b1, MD, 8'h10);
    wb(1'b1, L1, 8'hfe);
    wb(1'b1, H1, 8'hff);
    wb(1'b1, CT, 8'h40);
    wait_ovf(1);
    chk("ovf1 delay", 1, k >= 7 && k <= 15);
    wb(1'b1, CT, 8'h00);
    rchk("low1 wrap", L1, 8'h00);
    rchk("high1 wrap", H1, 8'h00);
  endtask : t_timer1
  initial begin
    {rst_b, cyc, stb, we, adr, sel, svc, wdat} = '0;
    clk_en = 1'b1;
    sel = 4'hf;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_carry();
    t_pin();
    t_gate();
    t_mode0();
    t_reload();
    t_split();
    t_timer1();
    test_done();
  end
endmodule : tmc_core_tb_top
